//--- common/fpsc_pkg.sv
// fpsc_pkg: constants, carrier types and shared helpers for the front panel
// settings controller; assumes a 20 MHz pclk and an APB register port.
`default_nettype none
package fpsc_pkg;
  // timing
  localparam int CLK_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYC = MS_NS / CLK_NS;
  localparam int IDLE_MIN = 5;
  localparam int IDLE_MS = IDLE_MIN * 60 * 1000;
  localparam int DEB_MS = 10;
  localparam int DERR_MS = 2000;
  localparam int SEC_MS = 1000;
  // register offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CLOCK = 8'h08;
  localparam logic [7:0] REG_EVT0 = 8'h10;
  localparam logic [7:0] REG_EVT3 = 8'h1c;
  // menu items
  localparam logic [3:0] IT_PROTO = 4'h0;
  localparam logic [3:0] IT_ADDR = 4'h1;
  localparam logic [3:0] IT_INFO = 4'h2;
  localparam logic [3:0] IT_FUNC = 4'h3;
  localparam logic [3:0] IT_UNOM = 4'h4;
  localparam logic [3:0] IT_RT0 = 4'h5;
  localparam logic [3:0] IT_RT3 = 4'h8;
  localparam logic [3:0] IT_CONF = 4'h9;
  // setting encodings and reset values
  localparam logic [1:0] FN_100 = 2'h1;
  localparam logic [1:0] FN_95 = 2'h2;
  localparam logic [1:0] FN_BOTH = 2'h3;
  localparam logic [2:0] BAUD_LAST = 3'h5;
  localparam logic [9:0] ADDR_MIN = 10'h001;
  localparam logic [9:0] ADDR_MAX = 10'h0ff;
  localparam logic [9:0] UNOM_MIN = 10'h064;
  localparam logic [9:0] UNOM_MAX = 10'h258;
  localparam logic [11:0] ADDR_RST = 12'h001;
  localparam logic [11:0] UNOM_RST = 12'h100;
  localparam logic [31:0] CLOCK_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    MD_STD, MD_BROWSE, MD_EDIT, MD_TARM, MD_TRDY, MD_CONF, MD_DERR
  } fpsc_mode_t;

  typedef struct packed {
    logic rst;
    logic sel;
    logic ent;
    logic dn;
    logic up;
  } fpsc_btn_t;

  typedef struct packed {
    logic modbus;
    logic [2:0] baud;
    logic [1:0] func;
    logic [11:0] addr;
    logic [11:0] unom;
  } fpsc_cfg_t;

  typedef struct packed {
    fpsc_mode_t mode;
    logic [1:0] fail;
    logic [3:0] trip;
    logic [3:0] item;
    logic blink;
    logic field;
    logic [1:0] digit;
    logic [15:0] val;
  } fpsc_disp_t;

  typedef struct packed {
    logic modbus;
    logic [2:0] baud;
    logic auto_baud;
    logic [7:0] station;
  } fpsc_ser_t;

  localparam fpsc_cfg_t CFG_RST = '{modbus: 1'b0, baud: BAUD_LAST, func: FN_BOTH,
                                   addr: ADDR_RST, unom: UNOM_RST};

  function automatic logic [9:0] fpsc_bcd2bin(input logic [11:0] v);
    return 10'(v[11:8]) * 10'd100 + 10'(v[7:4]) * 10'd10 + 10'(v[3:0]);
  endfunction : fpsc_bcd2bin

  function automatic logic [3:0] fpsc_digit(input logic [11:0] v, input logic [1:0] d);
    return v[d*4 +: 4];
  endfunction : fpsc_digit

  function automatic logic [11:0] fpsc_inc_digit(input logic [11:0] v, input logic [1:0] d);
    logic [11:0] r;
    logic [3:0] q;
    r = v;
    q = v[d*4 +: 4];
    q = (q >= 4'h9) ? 4'h0 : q + 4'h1;
    r[d*4 +: 4] = q;
    return r;
  endfunction : fpsc_inc_digit
endpackage : fpsc_pkg
`default_nettype wire

//--- logic/fpsc_ctrl.sv
// fpsc_ctrl: front panel settings, display and output relay test controller.
// assumes buttons and trip/fault inputs synchronous to pclk, APB slave port.
//
// Functional notes
// - protection runs on active copy; edits staged
// - enter, up to yes, enter commits staged
// - five idle minutes discard staged copy
// - enter opens session; cursor on first field
// - select button moves between two fields
// - digit select; up adds one or steps
// - second enter closes session, blinking stops
// - out-of-range value: data error, restore old
// - reset clears leds, relays, edits, display
// - relay test: enter, change, enter inverts
// - inverted relay holds until escape/reset/repeat
// - idle or reset returns standard display
// - trip message and led held until reset
// - fault shows cause, suspends input or all
// - protocol ascii or modbus with baud select
// - station address 1..255, match own traffic
// - clock stamps events, clears to epoch
// - function selection 100, 95 or both
// - injection nominal voltage 100..600 volts
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module fpsc_ctrl
  import fpsc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int IDLE_TICKS = IDLE_MS,
  parameter logic [15:0] SERIAL_ID = 16'h1234  // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fpsc_btn_t btn,
  input wire logic [3:0] trip_evt,
  input wire logic fault_pilot,
  input wire logic fault_hw,
  input wire logic [7:0] rx_addr,
  input wire logic rx_valid,
  output logic addr_match,
  output fpsc_disp_t disp,
  output fpsc_ser_t ser,
  output logic [3:0] relay_out,
  output logic [3:0] led_out,
  output logic en_100,
  output logic en_95,
  output logic first_digital_input_en,
  output logic func_en,
  output logic [9:0] injection_nominal_voltage,
  output logic [31:0] clock_secs
);

  typedef struct packed {
    fpsc_cfg_t act;
    fpsc_cfg_t stg;
    fpsc_mode_t mode;
    logic [3:0] item;
    logic field;
    logic [1:0] digit;
    logic [11:0] save;
    logic conf_yes;
    logic [3:0] tinv;
    logic [3:0] tripped;
    logic [3:0] leds;
    logic [3:0] trip_code;
    logic [1:0] flt;
    logic [14:0] tick;
    logic [18:0] idle;
    logic [11:0] derr;
    logic [9:0] secd;
    logic [31:0] secs;
    logic [4:0][3:0] deb;
    logic [4:0] stab;
    logic [4:0] press;
    logic [3:0][31:0] evt;
    logic [15:0] dval;
    logic blink;
    logic [3:0] rly;
    logic match;
    logic [31:0] rdat;
    logic err;
  } fpsc_st_t;

  fpsc_st_t s_r;
  fpsc_st_t s_nxt;
  fpsc_btn_t p;
  logic tick;
  logic timeout;
  logic numeric;
  logic [11:0] cur;
  logic [9:0] cur_bin;
  logic out_of_range;
  logic [3:0] rt_hot;

  assign p = fpsc_btn_t'(s_r.press);
  assign tick = (s_r.tick == 15'(TICK_CYCLES - 1));
  // one pulse per idle period; any press restarts the count
  assign timeout = tick && (s_r.idle == 19'(IDLE_TICKS - 1)) && (s_r.press == 5'h00);
  assign numeric = (s_r.item == IT_ADDR) || (s_r.item == IT_UNOM);
  assign cur = (s_r.item == IT_ADDR) ? s_r.stg.addr : s_r.stg.unom;
  assign cur_bin = fpsc_bcd2bin(cur);
  assign out_of_range = (s_r.item == IT_ADDR) ?
      (cur_bin < ADDR_MIN || cur_bin > ADDR_MAX) : (cur_bin < UNOM_MIN || cur_bin > UNOM_MAX);
  assign rt_hot = 4'h1 << 2'(s_r.item - IT_RT0);

  always_comb begin
    s_nxt = s_r;
    s_nxt.press = 5'h00;
    s_nxt.tick = tick ? 15'h0000 : s_r.tick + 15'h0001;
    // debounce on the ms tick: a level must hold DEB_MS ticks to count
    for (int i = 0; i < 5; i++) begin
      if (tick) begin
        if (btn[i] == s_r.stab[i]) begin
          s_nxt.deb[i] = 4'h0;
        end else if (s_r.deb[i] == 4'(DEB_MS - 1)) begin
          s_nxt.deb[i] = 4'h0;
          s_nxt.stab[i] = btn[i];
          s_nxt.press[i] = btn[i];
        end else begin
          s_nxt.deb[i] = s_r.deb[i] + 4'h1;
        end
      end
    end
    if (s_r.press != 5'h00) begin
      s_nxt.idle = 19'h00000;
    end else if (tick) begin
      s_nxt.idle = timeout ? 19'h00000 : s_r.idle + 19'h00001;
    end
    // wall clock: no battery, so reset value is the epoch
    if (tick) begin
      if (s_r.secd == 10'(SEC_MS - 1)) begin
        s_nxt.secd = 10'h000;
        s_nxt.secs = s_r.secs + 32'h0000_0001;
      end else begin
        s_nxt.secd = s_r.secd + 10'h001;
      end
    end
    s_nxt.flt = {fault_hw, fault_pilot};
    s_nxt.match = rx_valid && (rx_addr == 8'(fpsc_bcd2bin(s_r.act.addr)));

    // operator state machine
    if (p.rst) begin
      s_nxt.tripped = 4'h0;
      s_nxt.leds = 4'h0;
      s_nxt.trip_code = 4'h0;
      s_nxt.tinv = 4'h0;
      s_nxt.stg = s_r.act;
      s_nxt.mode = MD_STD;
    end else if (timeout) begin
      s_nxt.stg = s_r.act;
      s_nxt.mode = MD_STD;
    end else begin
      case (s_r.mode)
        MD_STD: begin
          if (p.up || p.dn) begin
            s_nxt.mode = MD_BROWSE;
            s_nxt.item = IT_PROTO;
          end
        end
        MD_BROWSE: begin
          // leaving a test item by arrow is the escape that drops the inversion
          if (p.up || p.dn) begin
            s_nxt.tinv = 4'h0;
            if (p.up) begin
              s_nxt.item = (s_r.item == IT_CONF) ? IT_PROTO : s_r.item + 4'h1;
            end else begin
              s_nxt.item = (s_r.item == IT_PROTO) ? IT_CONF : s_r.item - 4'h1;
            end
          end else if (p.ent) begin
            s_nxt.field = 1'b0;
            s_nxt.digit = 2'h0;
            s_nxt.save = cur;
            s_nxt.conf_yes = 1'b0;
            if (s_r.item >= IT_RT0 && s_r.item <= IT_RT3) begin
              s_nxt.mode = MD_TARM;
            end else if (s_r.item == IT_CONF) begin
              s_nxt.mode = MD_CONF;
            end else begin
              s_nxt.mode = MD_EDIT;
            end
          end
        end
        MD_EDIT: begin
          if (p.ent) begin
            if (numeric && out_of_range) begin
              s_nxt.mode = MD_DERR;
              s_nxt.derr = 12'h000;
              if (s_r.item == IT_ADDR) begin
                s_nxt.stg.addr = s_r.save;
              end else begin
                s_nxt.stg.unom = s_r.save;
              end
            end else begin
              s_nxt.mode = MD_BROWSE;
            end
          end else if (p.sel) begin
            if (numeric) begin
              s_nxt.digit = (s_r.digit == 2'h2) ? 2'h0 : s_r.digit + 2'h1;
            end else if (s_r.item == IT_PROTO && s_r.stg.modbus) begin
              s_nxt.field = ~s_r.field;
            end
          end else if (p.up) begin
            case (s_r.item)
              IT_ADDR: s_nxt.stg.addr = fpsc_inc_digit(s_r.stg.addr, s_r.digit);
              IT_UNOM: s_nxt.stg.unom = fpsc_inc_digit(s_r.stg.unom, s_r.digit);
              IT_FUNC: s_nxt.stg.func = (s_r.stg.func == FN_BOTH) ? FN_100 :
                                        s_r.stg.func + 2'h1;
              IT_PROTO: begin
                if (s_r.field) begin
                  s_nxt.stg.baud = (s_r.stg.baud == BAUD_LAST) ? 3'h0 :
                                   s_r.stg.baud + 3'h1;
                end else begin
                  s_nxt.stg.modbus = ~s_r.stg.modbus;
                  s_nxt.field = 1'b0;
                end
              end
              default: s_nxt.item = s_r.item;
            endcase
          end
        end
        MD_TARM: begin
          if (p.sel) begin
            s_nxt.mode = MD_TRDY;
          end else if (p.ent || p.up || p.dn) begin
            s_nxt.mode = MD_BROWSE;
          end
        end
        MD_TRDY: begin
          if (p.ent) begin
            // only one relay may be under test at a time
            s_nxt.tinv = (s_r.tinv & rt_hot) ^ rt_hot;
            s_nxt.mode = MD_BROWSE;
          end else if (p.up || p.dn) begin
            s_nxt.mode = MD_BROWSE;
          end
        end
        MD_CONF: begin
          if (p.up) begin
            s_nxt.conf_yes = 1'b1;
          end else if (p.dn) begin
            s_nxt.conf_yes = 1'b0;
          end else if (p.ent) begin
            if (s_r.conf_yes) begin
              s_nxt.act = s_r.stg;
            end
            s_nxt.mode = MD_BROWSE;
          end
        end
        MD_DERR: begin
          if (tick) begin
            s_nxt.derr = s_r.derr + 12'h001;
            if (s_r.derr == 12'(DERR_MS - 1)) begin
              s_nxt.mode = MD_BROWSE;
            end
          end
        end
        default: s_nxt.mode = MD_STD;
      endcase
    end

    // trip comes after the reset clear so a same-cycle trip is kept
    if (trip_evt != 4'h0) begin
      s_nxt.tripped = s_nxt.tripped | trip_evt;
      s_nxt.leds = s_nxt.leds | trip_evt;
      s_nxt.trip_code = trip_evt;
      s_nxt.evt[3:1] = s_r.evt[2:0];
      s_nxt.evt[0] = {trip_evt, s_r.secs[27:0]};
    end

    // APB: answer is prepared in the setup cycle, zero wait states
    if (psel && !penable) begin
      s_nxt.err = pwrite ? (paddr != REG_CLOCK) :
                  !(paddr == REG_CFG || paddr == REG_STAT || paddr == REG_CLOCK ||
                    (paddr >= REG_EVT0 && paddr <= REG_EVT3 && paddr[1:0] == 2'h0));
      case (paddr)
        REG_CFG: s_nxt.rdat = {6'h00, fpsc_bcd2bin(s_r.act.unom),
                               8'(fpsc_bcd2bin(s_r.act.addr)),
                               2'h0, s_r.act.func, s_r.act.baud, s_r.act.modbus};
        REG_STAT: s_nxt.rdat = {11'h000, s_r.field, s_r.digit, s_r.flt, s_r.rly, s_r.leds,
                                s_r.item, 1'b0, s_r.mode};
        REG_CLOCK: s_nxt.rdat = s_r.secs;
        default: s_nxt.rdat = s_nxt.err ? 32'h0000_0000 : s_r.evt[paddr[3:2]];
      endcase
    end
    if (psel && penable && pwrite && paddr == REG_CLOCK) begin
      s_nxt.secs = pwdata;
    end

    // display and relay outputs registered from the next state
    s_nxt.rly = s_nxt.tripped ^ s_nxt.tinv;
    s_nxt.blink = ((s_nxt.mode == MD_EDIT) && (s_nxt.item != IT_INFO)) ||
                  (s_nxt.mode == MD_TARM);
    case (s_nxt.item)
      IT_PROTO: s_nxt.dval = {11'h000, s_nxt.stg.modbus, 1'b0, s_nxt.stg.baud};
      IT_ADDR: s_nxt.dval = {4'h0, s_nxt.stg.addr};
      IT_INFO: s_nxt.dval = SERIAL_ID;
      IT_FUNC: s_nxt.dval = {14'h0000, s_nxt.stg.func};
      IT_UNOM: s_nxt.dval = {4'h0, s_nxt.stg.unom};
      IT_CONF: s_nxt.dval = {15'h0000, s_nxt.conf_yes};
      default: s_nxt.dval = {15'h0000, s_nxt.rly[2'(s_nxt.item - IT_RT0)]};
    endcase
    if (s_nxt.mode == MD_STD) begin
      s_nxt.dval = {14'h0000, s_nxt.act.func};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.act <= CFG_RST;
      s_r.stg <= CFG_RST;
      s_r.mode <= MD_STD;
      s_r.secs <= CLOCK_RST;
      s_r.dval <= {14'h0000, FN_BOTH};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pready = 1'b1;
  assign prdata = s_r.rdat;
  assign pslverr = s_r.err;
  assign addr_match = s_r.match;
  assign relay_out = s_r.rly;
  assign led_out = s_r.leds;
  assign disp = '{mode: s_r.mode, fail: s_r.flt, trip: s_r.trip_code, item: s_r.item,
                  blink: s_r.blink, field: s_r.field, digit: s_r.digit, val: s_r.dval};
  assign ser = '{modbus: s_r.act.modbus, baud: s_r.act.baud, auto_baud: !s_r.act.modbus,
                 station: 8'(fpsc_bcd2bin(s_r.act.addr))};
  assign en_100 = s_r.act.func[0] && !s_r.flt[1];
  assign en_95 = s_r.act.func[1] && !s_r.flt[1];
  assign first_digital_input_en = !s_r.flt[0] && !s_r.flt[1];
  assign func_en = !s_r.flt[1];
  assign injection_nominal_voltage = fpsc_bcd2bin(s_r.act.unom);
  assign clock_secs = s_r.secs;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_test_fire;
    s_r.mode == MD_TRDY && p.ent && !p.rst && !timeout;
  endsequence
  sequence s_bad_close;
    s_r.mode == MD_EDIT && p.ent && numeric && out_of_range && !p.rst && !timeout;
  endsequence

  AST_ACTIVE_ONLY_ON_YES: assert property (
    !$stable(s_r.act) |-> $past(s_r.mode) == MD_CONF && $past(s_r.conf_yes))
    else $error("active settings changed without confirmation");
  AST_COMMIT: assert property (
    s_r.mode == MD_CONF && s_r.conf_yes && p.ent && !p.rst && !timeout
    |=> s_r.act == $past(s_r.stg) && s_r.mode == MD_BROWSE)
    else $error("confirmed staged copy not committed");
  AST_TIMEOUT_DISCARD: assert property (
    timeout && !p.rst |=> s_r.stg == s_r.act && s_r.mode == MD_STD && disp.mode == MD_STD)
    else $error("idle timeout did not discard staged copy");
  AST_NO_CURSOR: assert property (
    s_r.mode == MD_EDIT |-> disp.blink == (s_r.item != IT_INFO))
    else $error("cursor shown wrongly in edit session");
  AST_DIGIT_UP: assert property (
    s_r.mode == MD_EDIT && s_r.item == IT_ADDR && p.up && !p.rst && !timeout
    |=> fpsc_digit(s_r.stg.addr, s_r.digit) ==
        4'((fpsc_digit($past(s_r.stg.addr), s_r.digit) + 4'h1) % 4'ha))
    else $error("digit did not step by one");
  AST_RANGE_RESTORE: assert property (
    s_bad_close |=> s_r.mode == MD_DERR && cur == $past(s_r.save) ##1
                    (s_r.mode == MD_DERR) [*3])
    else $error("out of range value not restored");
  AST_RESET_CLEARS: assert property (
    p.rst && trip_evt == 4'h0 |=> led_out == 4'h0 && relay_out == 4'h0 &&
                                  s_r.stg == s_r.act && s_r.mode == MD_STD)
    else $error("reset press did not clear state");
  AST_TEST_INVERT: assert property (
    (s_test_fire and (trip_evt == 4'h0)) |=>
      (relay_out & $past(rt_hot)) == (($past(relay_out) ^ $past(rt_hot)) & $past(rt_hot)))
    else $error("relay test did not invert the selected relay");
  AST_ONE_UNDER_TEST: assert property (
    $onehot0(s_r.tinv))
    else $error("more than one relay inverted by test");
  AST_TRIP_HOLD: assert property (
    trip_evt != 4'h0 |=> (led_out != 4'h0 && disp.trip != 4'h0) until p.rst)
    else $error("trip indication dropped before reset");
  AST_ADDR_MATCH: assert property (
    rx_valid && rx_addr != ser.station |=> !addr_match)
    else $error("foreign station address accepted");

endmodule : fpsc_ctrl
`default_nettype wire

//--- test/fpsc_operator.sv
// fpsc_operator: behavioural operator pressing the front panel push-buttons.
// assumes the controller debounces; every make and break is shown with bounce.
`timescale 1ns/1ns
`default_nettype none
module fpsc_operator
  import fpsc_pkg::*;
#(
  parameter int HOLD = 60
) (
  input wire logic pclk,
  output var fpsc_btn_t btn
);
  localparam logic [4:0] K_UP = 5'h01;
  localparam logic [4:0] K_SEL = 5'h08;
  localparam logic [4:0] K_ENT = 5'h04;

  initial btn = '0;

  // bounce on both edges; a clean edge would hide a weak debounce
  task automatic press(input logic [4:0] k);
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      btn <= fpsc_btn_t'(i[0] ? 5'h00 : k);
    end
    repeat (HOLD) @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      btn <= fpsc_btn_t'(i[0] ? k : 5'h00);
    end
    repeat (HOLD) @(posedge pclk);
  endtask : press

  task automatic commit();
    press(K_ENT);
    press(K_UP);
    press(K_ENT);
  endtask : commit

  task automatic relay_test();
    press(K_ENT);
    press(K_SEL);
    press(K_ENT);
  endtask : relay_test
endmodule : fpsc_operator
`default_nettype wire

//--- test/fpsc_ctrl_tb.sv
// fpsc_ctrl_tb: self-checking bench for the front panel settings controller.
// assumes short tick and idle parameters so the run stays brief.
`timescale 1ns/1ns
`default_nettype none
module fpsc_ctrl_tb;
  import fpsc_pkg::*;
  localparam logic [4:0] K_UP = 5'h01;
  localparam logic [4:0] K_DN = 5'h02;
  localparam logic [4:0] K_ENT = 5'h04;
  localparam logic [4:0] K_SEL = 5'h08;
  localparam logic [4:0] K_RST = 5'h10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fpsc_btn_t btn;
  logic [3:0] trip_evt = 4'h0;
  logic fault_pilot = 1'b0;
  logic fault_hw = 1'b0;
  logic [7:0] rx_addr = 8'h00;
  logic rx_valid = 1'b0;
  logic addr_match;
  fpsc_disp_t disp;
  fpsc_ser_t ser;
  logic [3:0] relay_out;
  logic [3:0] led_out;
  logic en_100;
  logic en_95;
  logic first_digital_input_en;
  logic func_en;
  logic [9:0] injection_nominal_voltage;
  logic [31:0] clock_secs;
  int err_total = 0;
  int samples_checked = 0;
  int m_station = 1;
  int m_evq[$];
  logic [31:0] rd;
  logic berr;
  logic [31:0] v;
  logic [31:0] cfg_exp;

  always #25 pclk = ~pclk;

  fpsc_ctrl #(.TICK_CYCLES(4), .IDLE_TICKS(50)) i_fpsc_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .btn(btn), .trip_evt(trip_evt), .fault_pilot(fault_pilot), .fault_hw(fault_hw),
    .rx_addr(rx_addr), .rx_valid(rx_valid), .addr_match(addr_match), .disp(disp),
    .ser(ser), .relay_out(relay_out), .led_out(led_out), .en_100(en_100), .en_95(en_95),
    .first_digital_input_en(first_digital_input_en), .func_en(func_en),
    .injection_nominal_voltage(injection_nominal_voltage), .clock_secs(clock_secs));

  fpsc_operator i_fpsc_operator (.pclk(pclk), .btn(btn));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    berr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      end_sim();
    end
  endtask : apb

  task automatic chk_bus(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0);
    samples_checked++;
    if ({berr, rd} !== {exp_err, exp}) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, {berr, rd}, {exp_err, exp});
    end
  endtask : chk_bus

  task automatic key(input logic [4:0] k, input int n);
    repeat (n) i_fpsc_operator.press(k);
  endtask : key

  initial begin
    void'($urandom(32'h89a4195c));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk(32'(disp.mode), 32'(MD_STD));
    chk(32'(disp.val), 32'(FN_BOTH));
    chk(32'({en_100, en_95}), 32'h3);
    chk(clock_secs, 32'h0);
    chk(32'(ser.station), 32'(m_station));
    chk(32'({ser.modbus, ser.baud, ser.auto_baud}), 32'h0b);
    chk(32'(injection_nominal_voltage), 32'd100);
    cfg_exp = {6'h0, 10'd100, 8'h01, 2'h0, FN_BOTH, BAUD_LAST, 1'b0};
    chk_bus(REG_CFG, cfg_exp, 1'b0);
    v = $urandom;
    apb(1'b1, REG_CLOCK, v);
    apb(1'b0, REG_CLOCK, 32'h0);
    chk(32'(rd - v > 32'h1), 32'h0);
    apb(1'b1, REG_CFG, 32'hffff_ffff);
    chk(32'(berr), 32'h1);
    chk_bus(REG_CFG, cfg_exp, 1'b0);
    chk_bus(8'h40, 32'h0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      rx_addr <= (i < 2) ? 8'(m_station) : 8'($urandom);
      rx_valid <= 1'b1;
      @(posedge pclk);
      rx_valid <= 1'b0;
      #1 chk(32'(addr_match), 32'(rx_addr == 8'(m_station)));
    end
    key(K_UP, 1);
    chk(32'({disp.mode, disp.item}), 32'({MD_BROWSE, IT_PROTO}));
    key(K_ENT, 1);
    chk(32'({disp.mode, disp.blink}), 32'({MD_EDIT, 1'b1}));
    key(K_UP, 1);
    key(K_ENT, 1);
    chk(32'({disp.blink, ser.modbus}), 32'h0);
    key(K_UP, 1);
    key(K_ENT, 1);
    key(K_UP, 1);
    chk(32'(disp.val[11:0]), 32'h002);
    key(K_SEL, 1);
    key(K_UP, 1);
    chk(32'(disp.val[11:0]), 32'h012);
    key(K_ENT, 1);
    chk(32'(ser.station), 32'(m_station));
    key(K_DN, 2);
    chk(32'(disp.item), 32'(IT_CONF));
    i_fpsc_operator.commit();
    m_station = 12;
    chk(32'(ser.station), 32'(m_station));
    chk(32'({ser.modbus, ser.auto_baud}), 32'h2);
    key(K_UP, 1);
    key(K_ENT, 1);
    key(K_SEL, 1);
    chk(32'(disp.field), 32'h1);
    key(K_UP, 1);
    chk(32'(disp.val[4:0]), 32'h10);
    key(K_ENT, 1);
    key(K_UP, 1);
    key(K_ENT, 1);
    key(K_UP, 1);
    key(K_ENT, 1);
    repeat (400) @(posedge pclk);
    chk(32'(disp.mode), 32'(MD_STD));
    key(K_UP, 2);
    chk(32'(disp.val[11:0]), 32'h012);
    chk(32'(ser.station), 32'(m_station));
    key(K_UP, 3);
    key(K_ENT, 1);
    key(K_SEL, 2);
    key(K_UP, 6);
    key(K_ENT, 1);
    chk(32'(disp.mode), 32'(MD_DERR));
    chk(32'(injection_nominal_voltage), 32'd100);
    chk(32'(disp.val[11:0]), 32'h100);
    for (int n = 0; n < 12000 && disp.mode === MD_DERR; n++) @(posedge pclk);
    chk(32'(disp.mode === MD_DERR), 32'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      trip_evt <= i[0] ? 4'h8 : 4'h2;
      @(posedge pclk);
      trip_evt <= 4'h0;
      m_evq.push_front(i[0] ? 8 : 2);
    end
    repeat (2) @(posedge pclk);
    chk(32'({led_out, relay_out}), 32'haa);
    chk(32'(disp.trip[3]), 32'h1);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, REG_EVT0 + 8'(4 * i), 32'h0);
      chk(32'(rd[31:28]), 32'(m_evq[i]));
    end
    key(K_RST, 1);
    chk(32'({led_out, relay_out, disp.mode}), 32'(MD_STD));
    key(K_UP, 1);
    key(K_DN, 3);
    key(K_ENT, 1);
    chk(32'({disp.mode, disp.blink}), 32'({MD_TARM, 1'b1}));
    key(K_SEL, 1);
    key(K_ENT, 1);
    chk(32'(relay_out), 32'h4);
    i_fpsc_operator.relay_test();
    chk(32'(relay_out), 32'h0);
    i_fpsc_operator.relay_test();
    key(K_UP, 1);
    chk(32'(relay_out), 32'h0);
    fault_pilot <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'({disp.fail, first_digital_input_en, func_en}), 32'h5);
    fault_hw <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'({disp.fail, func_en}), 32'h6);
    end_sim();
  end
endmodule : fpsc_ctrl_tb
`default_nettype wire
